/* core/sgrc_pkg.sv */
package sgrc_pkg;
   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLK_GATE = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // sleep_control fields
   localparam int SC_ARM_BIT = 5;
   localparam int SC_MODE_LSB = 3;
   localparam logic [7:0] SC_WRITE_MASK = 8'h38;
   localparam logic [7:0] SC_RESET = 8'h00;

   // peripheral_clock_gate fields
   localparam int GATE_TWO_WIRE = 7;
   localparam int GATE_SERIAL_PORT1 = 6;
   localparam int GATE_SERIAL_PORT0 = 5;
   localparam int GATE_SERIAL_PERIPHERAL = 4;
   localparam int GATE_TIMER2 = 3;
   localparam int GATE_TIMER1 = 2;
   localparam int GATE_TIMER0 = 1;
   localparam int GATE_CONVERTER = 0;
   localparam int NUM_PERIPH = 8;
   localparam logic [7:0] GATE_RESET = 8'h00;

   // status fields
   localparam int ST_MODE_LSB = 0;
   localparam int ST_SLEEPING_BIT = 2;
   localparam int ST_WAKING_BIT = 3;

   typedef enum logic [1:0] {
      SGRC_MODE_IDLE = 2'h0,
      SGRC_MODE_CONV_NOISE = 2'h1,
      SGRC_MODE_POWER_DOWN = 2'h2,
      SGRC_MODE_STANDBY = 2'h3
   } sgrc_mode_t;

   typedef struct packed {
      logic cpu;
      logic io;
      logic conv;
   } sgrc_clk_en_t;

   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int CLK_MHZ = 20;
   localparam int TICK_DIV = CLK_MHZ;
   localparam int STARTUP_TIMEOUT_US = 64;
   localparam int WDT_PULSE_NS = 100;
   localparam int WDT_PULSE_CYC =
      (WDT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_HALT_CYC = 4;
   localparam int STBY_WAKE_CYC = 6;
   localparam int STBY_STARTUP_CYC = STBY_WAKE_CYC - WAKE_HALT_CYC;
   localparam int PDOWN_STARTUP_CYC = 16;
   localparam int DLY_W = 16;
   localparam int WAIT_W = 8;
   localparam int DIV_W = 8;
endpackage : sgrc_pkg

/* core/sgrc_tick_div.sv */
`timescale 1ns/1ns
module sgrc_tick_div
   import sgrc_pkg::*;
#(
   parameter logic [DIV_W-1:0] DIV = DIV_W'(TICK_DIV)
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   output logic tick_o
);
   logic [DIV_W-1:0] cnt_r;

   // free-running, reset only by the chip reset so stretching keeps timing
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end else if (cnt_r == DIV - DIV_W'(1)) begin
         cnt_r <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r + DIV_W'(1);
         tick_o <= 1'b0;
      end
   end
endmodule : sgrc_tick_div

/* core/sgrc_top.sv */
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module sgrc_top
   import sgrc_pkg::*;
#(
   parameter logic [DLY_W-1:0] TOUT_TICKS = DLY_W'(STARTUP_TIMEOUT_US)
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic sleep_instr_i,
   input wire logic wake_irq_i,
   input wire logic supply_below_rise_i,
   input wire logic ext_reset_en_i,
   input wire logic ext_reset_n_i,
   input wire logic wdt_enable_i,
   input wire logic wdt_expire_i,
   input wire logic droop_det_en_i,
   input wire logic droop_below_i,
   output logic core_reset_o,
   output logic port_reset_o,
   output logic core_halt_o,
   output logic irq_service_o,
   output sgrc_clk_en_t clk_en_o,
   output logic [NUM_PERIPH-1:0] periph_clk_en_o,
   output logic [NUM_PERIPH-1:0] periph_access_en_o,
   output logic comparator_en_o,
   output logic in_buf_en_o,
   output logic wdt_run_o
);
   typedef enum logic [1:0] {
      SGRC_ST_ACTIVE,
      SGRC_ST_SLEEP,
      SGRC_ST_STARTUP,
      SGRC_ST_HALT
   } sgrc_state_t;

   ////////////////////////////////////////////////////////////////////////
   // reset sources

   logic src_por;
   logic src_pin;
   logic src_droop;
   logic arst;
   logic tick;
   logic [WAIT_W-1:0] wdt_cnt_r;
   logic wdt_pulse;
   logic wdt_fall;
   logic [DLY_W-1:0] dly_cnt_r;
   logic stretch_r;

   assign src_por = supply_below_rise_i;
   assign src_pin = ext_reset_en_i & ~ext_reset_n_i;
   assign src_droop = droop_det_en_i & droop_below_i;
   // asynchronous sources, no clock needed to assert
   assign arst = rst_i | src_por | src_pin | src_droop;

   sgrc_tick_div u_tick (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_o(tick)
   );

   // watchdog source is a short synchronous pulse
   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         wdt_cnt_r <= '0;
      end else if (wdt_cnt_r != '0) begin
         wdt_cnt_r <= wdt_cnt_r - WAIT_W'(1);
      end else if (wdt_enable_i && wdt_expire_i && !stretch_r) begin
         wdt_cnt_r <= WAIT_W'(WDT_PULSE_CYC);
      end
   end

   assign wdt_pulse = (wdt_cnt_r != '0);
   assign wdt_fall = (wdt_cnt_r == WAIT_W'(1));

   // delay counter: cleared while any source is active, counts once idle
   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         dly_cnt_r <= '0;
         stretch_r <= 1'b1;
      end else if (wdt_pulse && !wdt_fall) begin
         dly_cnt_r <= '0;
         stretch_r <= 1'b1;
      end else if (wdt_fall) begin
         dly_cnt_r <= '0;
         stretch_r <= 1'b1;
      end else if (stretch_r && tick) begin
         if (dly_cnt_r == TOUT_TICKS - DLY_W'(1)) begin
            stretch_r <= 1'b0;
         end else begin
            dly_cnt_r <= dly_cnt_r + DLY_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         core_reset_o <= 1'b1;
      end else begin
         core_reset_o <= stretch_r || wdt_pulse;
      end
   end

   // port pins follow the sources themselves, not the stretch
   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         port_reset_o <= 1'b1;
      end else begin
         port_reset_o <= wdt_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   logic [DATA_W-1:0] sleep_ctrl_r;
   logic [DATA_W-1:0] gate_r;
   logic sleep_arm;
   sgrc_mode_t sel_mode;

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         sleep_ctrl_r <= SC_RESET;
      end else if (core_reset_o) begin
         sleep_ctrl_r <= SC_RESET;
      end else if (wr_i && addr_i == ADDR_SLEEP_CTRL) begin
         sleep_ctrl_r <= wdata_i & SC_WRITE_MASK;
      end
   end

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         gate_r <= GATE_RESET;
      end else if (core_reset_o) begin
         gate_r <= GATE_RESET;
      end else if (wr_i && addr_i == ADDR_CLK_GATE) begin
         gate_r <= wdata_i;
      end
   end

   assign sleep_arm = sleep_ctrl_r[SC_ARM_BIT];
   assign sel_mode = sgrc_mode_t'(sleep_ctrl_r[SC_MODE_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////////
   // sleep sequencing

   sgrc_state_t state_r;
   sgrc_state_t state_nxt;
   sgrc_mode_t mode_r;
   logic [WAIT_W-1:0] wait_r;
   logic [WAIT_W-1:0] wait_nxt;
   logic [WAIT_W-1:0] startup_len;
   logic serve_nxt;

   // oscillator restart only costs time when it was stopped
   always_comb begin
      case (mode_r)
         SGRC_MODE_STANDBY: startup_len = WAIT_W'(STBY_STARTUP_CYC);
         SGRC_MODE_POWER_DOWN: startup_len = WAIT_W'(PDOWN_STARTUP_CYC);
         default: startup_len = '0;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      serve_nxt = 1'b0;
      case (state_r)
         SGRC_ST_ACTIVE: begin
            if (sleep_instr_i && sleep_arm) begin
               state_nxt = SGRC_ST_SLEEP;
            end
         end
         SGRC_ST_SLEEP: begin
            if (wake_irq_i) begin
               if (startup_len == '0) begin
                  state_nxt = SGRC_ST_HALT;
                  wait_nxt = WAIT_W'(WAKE_HALT_CYC - 1);
               end else begin
                  state_nxt = SGRC_ST_STARTUP;
                  wait_nxt = startup_len - WAIT_W'(1);
               end
            end
         end
         SGRC_ST_STARTUP: begin
            if (wait_r == '0) begin
               state_nxt = SGRC_ST_HALT;
               wait_nxt = WAIT_W'(WAKE_HALT_CYC - 1);
            end else begin
               wait_nxt = wait_r - WAIT_W'(1);
            end
         end
         SGRC_ST_HALT: begin
            if (wait_r == '0) begin
               state_nxt = SGRC_ST_ACTIVE;
               serve_nxt = 1'b1;
            end else begin
               wait_nxt = wait_r - WAIT_W'(1);
            end
         end
         default: begin
            state_nxt = SGRC_ST_ACTIVE;
         end
      endcase
   end

   // a reset during sleep wakes straight to the reset vector
   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         state_r <= SGRC_ST_ACTIVE;
         wait_r <= '0;
      end else if (core_reset_o) begin
         state_r <= SGRC_ST_ACTIVE;
         wait_r <= '0;
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
      end
   end

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         mode_r <= SGRC_MODE_IDLE;
      end else if (state_r != state_nxt && state_nxt == SGRC_ST_SLEEP) begin
         mode_r <= sel_mode;
      end
   end

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         irq_service_o <= 1'b0;
         core_halt_o <= 1'b0;
      end else begin
         irq_service_o <= serve_nxt && !core_reset_o;
         core_halt_o <= (state_nxt != SGRC_ST_ACTIVE) && !core_reset_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock domains and gating

   sgrc_clk_en_t dom_nxt;
   logic asleep_nxt;

   assign asleep_nxt = (state_nxt == SGRC_ST_SLEEP) ||
                       (state_nxt == SGRC_ST_STARTUP);

   always_comb begin
      dom_nxt.cpu = !core_reset_o && (state_nxt == SGRC_ST_ACTIVE);
      dom_nxt.io = 1'b1;
      dom_nxt.conv = 1'b1;
      if (asleep_nxt) begin
         case (state_r == SGRC_ST_ACTIVE ? sel_mode : mode_r)
            SGRC_MODE_IDLE: begin
               dom_nxt.io = 1'b1;
               dom_nxt.conv = 1'b1;
            end
            SGRC_MODE_CONV_NOISE: begin
               dom_nxt.io = 1'b0;
               dom_nxt.conv = 1'b1;
            end
            default: begin
               dom_nxt.io = 1'b0;
               dom_nxt.conv = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         clk_en_o <= '0;
         in_buf_en_o <= 1'b0;
         comparator_en_o <= 1'b0;
         wdt_run_o <= 1'b0;
      end else begin
         clk_en_o <= dom_nxt;
         in_buf_en_o <= dom_nxt.io || dom_nxt.conv;
         comparator_en_o <= !gate_r[GATE_CONVERTER];
         wdt_run_o <= wdt_enable_i;
      end
   end

   // one enable per peripheral; converter on its own domain
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_gate
         logic dom_on;
         if (gi == GATE_CONVERTER) begin : g_conv
            assign dom_on = dom_nxt.conv;
         end else begin : g_io
            assign dom_on = dom_nxt.io;
         end
         always_ff @(posedge core_clk_i or posedge arst) begin
            if (arst) begin
               periph_clk_en_o[gi] <= 1'b0;
               periph_access_en_o[gi] <= 1'b0;
            end else begin
               periph_clk_en_o[gi] <= dom_on && !gate_r[gi];
               periph_access_en_o[gi] <= !gate_r[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read port

   logic [DATA_W-1:0] rdata_nxt;

   always_comb begin
      rdata_nxt = RDATA_UNMAPPED;
      case (addr_i)
         ADDR_SLEEP_CTRL: rdata_nxt = sleep_ctrl_r & SC_WRITE_MASK;
         ADDR_CLK_GATE: rdata_nxt = gate_r;
         ADDR_STATUS: begin
            rdata_nxt[ST_MODE_LSB +: 2] = mode_r;
            rdata_nxt[ST_SLEEPING_BIT] = (state_r == SGRC_ST_SLEEP);
            rdata_nxt[ST_WAKING_BIT] = (state_r == SGRC_ST_STARTUP) ||
                                       (state_r == SGRC_ST_HALT);
         end
         default: rdata_nxt = RDATA_UNMAPPED;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge arst) begin
      if (arst) begin
         rdata_o <= RDATA_UNMAPPED;
      end else if (rd_i) begin
         rdata_o <= rdata_nxt;
      end else begin
         rdata_o <= RDATA_UNMAPPED;
      end
   end
endmodule : sgrc_top

/* bench/sgrc_periph_model.sv */
`timescale 1ns/1ns
module sgrc_periph_model
   import sgrc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   output logic [7:0] count_o
);
   // stands in for a timer: advances only on its enabled clock
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i)
         count_o <= 8'h00;
      else if (clk_en_i)
         count_o <= count_o + 8'h01;
   end
endmodule : sgrc_periph_model

/* bench/sgrc_checker.sv */
`timescale 1ns/1ns
module sgrc_checker
   import sgrc_pkg::*;
#(
   parameter logic [DLY_W-1:0] TOUT_TICKS = DLY_W'(STARTUP_TIMEOUT_US)
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic sleep_instr_i,
   input wire logic supply_below_rise_i,
   input wire logic ext_reset_en_i,
   input wire logic ext_reset_n_i,
   input wire logic wdt_enable_i,
   input wire logic wdt_expire_i,
   input wire logic droop_det_en_i,
   input wire logic droop_below_i,
   input wire logic core_reset_o,
   input wire logic port_reset_o,
   input wire logic core_halt_o,
   input wire logic irq_service_o,
   input wire sgrc_clk_en_t clk_en_o,
   input wire logic [NUM_PERIPH-1:0] periph_access_en_o,
   input wire logic comparator_en_o,
   input wire logic in_buf_en_o
);
   logic arm_r;

   // shadow of the sleep_arm bit as software last wrote it
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i)
         arm_r <= 1'b0;
      else if (core_reset_o)
         arm_r <= 1'b0;
      else if (wr_i && addr_i == ADDR_SLEEP_CTRL)
         arm_r <= wdata_i[SC_ARM_BIT];
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   chk_pin_reset: assert property (
      (ext_reset_en_i && !ext_reset_n_i)
      |-> port_reset_o && core_reset_o) else $error("pin reset missed");
   chk_droop_reset: assert property (
      (droop_det_en_i && droop_below_i)
      |-> port_reset_o && core_reset_o) else $error("droop reset missed");
   chk_supply_reset: assert property (supply_below_rise_i
      |-> port_reset_o && core_reset_o) else $error("supply reset missed");
   chk_stretch_hold: assert property ($fell(port_reset_o)
      |-> core_reset_o [*8]) else $error("reset not stretched");
   chk_wdt_off: assert property ((wdt_expire_i && !wdt_enable_i
      && !core_reset_o) |=> !core_reset_o) else $error("wdt reset off");
   chk_gate_apply: assert property ((wr_i && !core_reset_o
      && addr_i == ADDR_CLK_GATE) |-> ##2
      periph_access_en_o == ~$past(wdata_i, 2)) else $error("gate lost");
   chk_comp_follow: assert property (comparator_en_o
      == periph_access_en_o[GATE_CONVERTER]) else $error("comparator");
   chk_ctrl_reserved: assert property ((rd_i && !core_reset_o
      && addr_i == ADDR_SLEEP_CTRL) |=> (rdata_o & 8'hC4) == 8'h00)
      else $error("reserved bits set");
   chk_arm_off: assert property ((sleep_instr_i && !arm_r
      && !core_halt_o && !core_reset_o) |=> !core_halt_o)
      else $error("slept unarmed");
   chk_arm_on: assert property ((sleep_instr_i && arm_r
      && !core_halt_o && !core_reset_o) |=> core_halt_o && !clk_en_o.cpu)
      else $error("no sleep");
   chk_buf_off: assert property ((!clk_en_o.io && !clk_en_o.conv)
      |-> !in_buf_en_o) else $error("input buffers on");
   chk_irq_pulse: assert property ($rose(irq_service_o)
      |=> !irq_service_o && !core_halt_o) else $error("service pulse");
endmodule : sgrc_checker

bind sgrc_top sgrc_checker #(.TOUT_TICKS(TOUT_TICKS)) u_chk (.core_clk_i,
   .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_instr_i,
   .supply_below_rise_i, .ext_reset_en_i, .ext_reset_n_i, .wdt_enable_i,
   .wdt_expire_i, .droop_det_en_i, .droop_below_i, .core_reset_o,
   .port_reset_o, .core_halt_o, .irq_service_o, .clk_en_o,
   .periph_access_en_o, .comparator_en_o, .in_buf_en_o);

/* bench/sgrc_top_tb.sv */
`timescale 1ns/1ns
module sgrc_top_tb import sgrc_pkg::*; ;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d, v, c, cnt;
   logic wr_i = 1'b0, rd_i = 1'b0, sleep_instr_i = 1'b0, wake_irq_i = 1'b0;
   logic supply_below_rise_i = 1'b0;
   logic ext_reset_en_i = 1'b0, ext_reset_n_i = 1'b1;
   logic wdt_enable_i = 1'b0, wdt_expire_i = 1'b0;
   logic droop_det_en_i = 1'b0, droop_below_i = 1'b0;
   logic core_reset_o, port_reset_o, core_halt_o, irq_service_o;
   logic comparator_en_o, in_buf_en_o, wdt_run_o;
   logic [7:0] periph_clk_en_o, periph_access_en_o;
   sgrc_clk_en_t clk_en_o;
   int num_errors = 0;
   int samples_checked = 0;
   int n, m, ex;

   always #25 core_clk_i = ~core_clk_i;

   sgrc_top #(.TOUT_TICKS(16'h0002)) i_dut (.core_clk_i, .rst_i, .addr_i,
      .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_instr_i, .wake_irq_i,
      .supply_below_rise_i, .ext_reset_en_i, .ext_reset_n_i, .wdt_enable_i,
      .wdt_expire_i, .droop_det_en_i, .droop_below_i, .core_reset_o,
      .port_reset_o, .core_halt_o, .irq_service_o, .clk_en_o,
      .periph_clk_en_o, .periph_access_en_o, .comparator_en_o,
      .in_buf_en_o, .wdt_run_o);

   sgrc_periph_model i_tmr (.core_clk_i, .rst_i,
      .clk_en_i(periph_clk_en_o[GATE_TIMER0]), .count_o(cnt));

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp_v);
      samples_checked++;
      if (seen !== exp_v) begin
         num_errors++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp_v);
      end
   endtask : chk

   function automatic logic [7:0] rng(input int k, input int lo);
      return {7'h00, k >= lo && k <= lo + 50};
   endfunction : rng

   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= dat;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      dat = rdata_o;
   endtask : rd

   // one-cycle pulse: 0 sleep instruction, 1 watchdog expiry
   task automatic pulse(input int w);
      @(posedge core_clk_i);
      if (w == 0)
         sleep_instr_i <= 1'b1;
      else
         wdt_expire_i <= 1'b1;
      @(posedge core_clk_i);
      sleep_instr_i <= 1'b0;
      wdt_expire_i <= 1'b0;
   endtask : pulse

   task automatic wait_rel(output int k);
      k = 0;
      while (core_reset_o !== 1'b0 && k < 300) begin
         @(posedge core_clk_i);
         #1;
         k++;
      end
      if (k >= 300) begin
         chk(8'h00, 8'h01);
         test_done();
      end
   endtask : wait_rel

   ////////////////////////////////////////////////////////////////////////
   initial begin
      v = 8'($urandom(3928));
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      wait_rel(n);
      chk(rng(n, 20), 8'h01);
      rd(ADDR_SLEEP_CTRL, d);
      chk(d, SC_RESET);
      rd(ADDR_CLK_GATE, d);
      chk(d, GATE_RESET);
      rd(8'h05, d);
      chk(d, RDATA_UNMAPPED);
      for (m = 0; m < 16; m++) begin
         v = 8'($urandom);
         wr(ADDR_SLEEP_CTRL, v);
         rd(ADDR_SLEEP_CTRL, d);
         chk(d, v & SC_WRITE_MASK);
         v = (m == 0) ? 8'hFF : 8'($urandom);
         wr(ADDR_CLK_GATE, v);
         rd(ADDR_CLK_GATE, d);
         chk(d, v);
         chk(periph_access_en_o, ~v);
         chk(periph_clk_en_o, ~v);
         chk({7'h00, comparator_en_o}, {7'h00, ~v[0]});
      end
      // timer frozen while gated, moves again once released
      wr(ADDR_CLK_GATE, 8'h02);
      repeat (3) @(posedge core_clk_i);
      #1;
      c = cnt;
      repeat (10) @(posedge core_clk_i);
      #1;
      chk(cnt, c);
      wr(ADDR_CLK_GATE, 8'h00);
      repeat (4) @(posedge core_clk_i);
      #1;
      chk({7'h00, cnt != c}, 8'h01);
      for (m = 0; m < 4; m++) begin
         wdt_enable_i <= 1'b1;
         wr(ADDR_SLEEP_CTRL, 8'(m << SC_MODE_LSB));
         pulse(0);
         repeat (3) @(posedge core_clk_i);
         #1;
         chk({7'h00, core_halt_o}, 8'h00);
         wr(ADDR_SLEEP_CTRL, 8'h20 | 8'(m << SC_MODE_LSB));
         pulse(0);
         repeat (2) @(posedge core_clk_i);
         #1;
         chk({5'h00, core_halt_o, clk_en_o.cpu, in_buf_en_o},
            {5'h00, 2'b10, m < 2});
         chk({6'h00, clk_en_o.io, clk_en_o.conv},
            {6'h00, m == 0, m < 2});
         chk({7'h00, wdt_run_o}, 8'h01);
         rd(ADDR_STATUS, d);
         c = 8'(m << ST_MODE_LSB) | (8'h01 << ST_SLEEPING_BIT);
         chk(d, c);
         wake_irq_i <= 1'b1;
         n = 0;
         while (irq_service_o !== 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            #1;
            n++;
         end
         wake_irq_i <= 1'b0;
         ex = (m == 2) ? 20 : (m == 3) ? 6 : 4;
         chk({7'h00, n >= ex && n <= ex + 2}, 8'h01);
         wr(ADDR_SLEEP_CTRL, 8'h00);
      end
      wr(ADDR_CLK_GATE, 8'hA5);
      wdt_enable_i <= 1'b0;
      pulse(1);
      repeat (3) @(posedge core_clk_i);
      #1;
      chk({7'h00, core_reset_o}, 8'h00);
      wdt_enable_i <= 1'b1;
      pulse(1);
      @(posedge core_clk_i);
      #1;
      chk({6'h00, port_reset_o, core_reset_o}, 8'h03);
      wait_rel(n);
      chk(rng(n, 20), 8'h01);
      rd(ADDR_CLK_GATE, d);
      chk(d, GATE_RESET);
      droop_below_i <= 1'b1;
      ext_reset_n_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk({7'h00, core_reset_o}, 8'h00);
      ext_reset_n_i <= 1'b1;
      // each source raised and dropped between clock edges, then held
      for (m = 0; m < 6; m++) begin
         @(posedge core_clk_i);
         #7;
         ext_reset_en_i = 1'b1;
         supply_below_rise_i = (m % 3 == 0);
         ext_reset_n_i = (m % 3 != 1);
         droop_det_en_i = (m % 3 == 2);
         #3;
         chk({6'h00, port_reset_o, core_reset_o}, 8'h03);
         #5;
         if (m >= 3) begin
            repeat (3) @(posedge core_clk_i);
            #7;
            chk({6'h00, port_reset_o, core_reset_o}, 8'h03);
         end
         supply_below_rise_i = 1'b0;
         ext_reset_n_i = 1'b1;
         droop_det_en_i = 1'b0;
         wait_rel(n);
         chk(rng(n, 20), 8'h01);
      end
      test_done();
   end
endmodule : sgrc_top_tb
